// ===== pkg/rtc_pkg.sv
package rtc_pkg;
    // Special function register addresses.
    localparam logic [7:0] RTC_ADDR_CONFIG    = 8'ha1;
    localparam logic [7:0] RTC_ADDR_FRAC      = 8'ha2;
    localparam logic [7:0] RTC_ADDR_SEC       = 8'ha3;
    localparam logic [7:0] RTC_ADDR_MIN       = 8'ha4;
    localparam logic [7:0] RTC_ADDR_HOUR      = 8'ha5;
    localparam logic [7:0] RTC_ADDR_IVAL      = 8'ha6;
    localparam logic [7:0] RTC_ADDR_NOM_TRIM  = 8'hf6;
    localparam logic [7:0] RTC_ADDR_TEMP_TRIM = 8'hf7;
    localparam logic [7:0] RTC_ADDR_KEY       = 8'hc1;
    localparam logic [7:0] RTC_ADDR_INT_PIN   = 8'hff;

    // Configuration register field positions.
    localparam int RTC_CFG_MIDNIGHT = 7;
    localparam int RTC_CFG_DAY_MODE = 6;
    localparam int RTC_CFG_BASE_HI  = 5;
    localparam int RTC_CFG_BASE_LO  = 4;
    localparam int RTC_CFG_SINGLE   = 3;
    localparam int RTC_CFG_ALARM    = 2;
    localparam int RTC_CFG_TMR_EN   = 1;
    localparam int RTC_CFG_RSVD     = 0;

    // Reset values and constants.
    localparam logic [7:0] RTC_CFG_RESET    = 8'h01;
    localparam logic [7:0] RTC_KEY_UNLOCK   = 8'hea;
    localparam logic [7:0] RTC_FRAC_TOP     = 8'h7f;
    localparam logic [7:0] RTC_MIN_SEC_TOP  = 8'h3b;
    localparam logic [7:0] RTC_HOUR_TOP_24  = 8'h17;
    localparam logic [7:0] RTC_HOUR_TOP_256 = 8'hff;

    // Crystal edges per 1/128 second: 32768 Hz / 128.
    localparam int         RTC_XTAL_HZ      = 32768;
    localparam int         RTC_TICKS_PER_S  = 128;
    localparam logic [9:0] RTC_XTAL_PER_TICK = 10'(RTC_XTAL_HZ / RTC_TICKS_PER_S);

    // Interval timer time base codes.
    typedef enum logic [1:0] {
        RTC_BASE_FRAC = 2'h0,
        RTC_BASE_SEC  = 2'h1,
        RTC_BASE_MIN  = 2'h2,
        RTC_BASE_HOUR = 2'h3
    } rtc_base_t;
endpackage

// ===== src/rtc_core.sv
`timescale 1ns/1ps
module rtc_core
    import rtc_pkg::*;
(
    input  wire logic       clk,          // 50 MHz system clock.
    input  wire logic       rstn,         // Power-on reset, asynchronous, active low.
    input  wire logic       soft_rstn,    // Watchdog or pin reset, synchronous, active low.
    input  wire logic       xtal_clk,     // Crystal oscillator pin, 32.768 kHz.
    input  wire logic [7:0] sfr_addr,     // Register address.
    input  wire logic [7:0] sfr_wdata,    // Write data byte.
    input  wire logic       sfr_wr,       // Write strobe, one cycle.
    input  wire logic       sfr_rd,       // Read strobe, one cycle.
    output logic      [7:0] sfr_rdata,    // Read data, valid the cycle after sfr_rd.
    output logic      [7:0] int_pin_cfg,  // Interrupt pin configuration byte.
    output logic            alarm_flag,   // Interval alarm flag.
    output logic            midnight_flag,// Midnight flag.
    output logic            sleep_block   // High while sleep entry is refused.
);
    import rtc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Wrap-around increment shared by all time counters.
    function automatic logic [7:0] rtc_wrap_inc(input logic [7:0] v, input logic [7:0] top);
        rtc_wrap_inc = (v == top) ? 8'h00 : 8'(v + 8'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // The crystal pin is foreign to clk, so it passes two flops before the edge detector.
    logic xs1_q, xs2_q, xs3_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
        end else begin
            xs1_q <= xtal_clk;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
        end
    end
    logic xtal_edge;
    assign xtal_edge = xs2_q & ~xs3_q;

    ////////////////////////////////////////////////////////////////////////////////
    // State registers. Only rstn clears time, day mode and trims; soft reset leaves them.
    logic [7:0] cfg_q, cfg_d, frac_q, frac_d, sec_q, sec_d, min_q, min_d, hour_q, hour_d;
    logic [7:0] ivl_q, ivl_d, nom_q, nom_d, temp_q, temp_d, key_q, key_d;
    logic [7:0] pin_q, pin_d, itcnt_q, itcnt_d, rdata_d;
    logic [9:0] pre_q, pre_d;
    logic       done_q, done_d;

    // Tick chain and decode, combinational.
    logic       unlocked, tick128, sec_tick, min_tick, hour_tick, midnight_evt, base_tick;
    logic       wr_cfg, wr_frac, wr_sec, wr_min, wr_hour, wr_pin;
    logic [7:0] hour_top;
    logic [9:0] tick_len;
    logic signed [9:0] trim_sum;

    // Both trims add; the sum shortens or stretches the first tick of every second.
    assign trim_sum = 10'(signed'(nom_q)) + 10'(signed'(temp_q));
    assign tick_len = (frac_q == 8'h00) ? 10'(RTC_XTAL_PER_TICK - trim_sum) : RTC_XTAL_PER_TICK;
    // Counting depends on no power mode input, so it never stops in low power states.
    assign tick128  = xtal_edge && (pre_q >= 10'(tick_len - 10'd1));
    assign sec_tick = tick128 && (frac_q == RTC_FRAC_TOP);
    assign min_tick = sec_tick && (sec_q == RTC_MIN_SEC_TOP);
    assign hour_tick = min_tick && (min_q == RTC_MIN_SEC_TOP);
    assign hour_top = cfg_q[RTC_CFG_DAY_MODE] ? RTC_HOUR_TOP_24 : RTC_HOUR_TOP_256;
    assign midnight_evt = hour_tick && (hour_q == hour_top);

    // Protected writes go through only with the key in place; whole bytes only.
    assign unlocked = (key_q == RTC_KEY_UNLOCK);
    assign wr_cfg   = sfr_wr && (sfr_addr == RTC_ADDR_CONFIG);
    assign wr_frac  = sfr_wr && unlocked && (sfr_addr == RTC_ADDR_FRAC);
    assign wr_sec   = sfr_wr && unlocked && (sfr_addr == RTC_ADDR_SEC);
    assign wr_min   = sfr_wr && unlocked && (sfr_addr == RTC_ADDR_MIN);
    assign wr_hour  = sfr_wr && unlocked && (sfr_addr == RTC_ADDR_HOUR);
    assign wr_pin   = sfr_wr && unlocked && (sfr_addr == RTC_ADDR_INT_PIN);

    // Interval timer tick source.
    always_comb begin
        unique case (rtc_base_t'(cfg_q[RTC_CFG_BASE_HI:RTC_CFG_BASE_LO]))
            RTC_BASE_FRAC: base_tick = tick128;
            RTC_BASE_SEC:  base_tick = sec_tick;
            RTC_BASE_MIN:  base_tick = min_tick;
            RTC_BASE_HOUR: base_tick = hour_tick;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic. A software write to a counter beats a carry in the same cycle.
    always_comb begin
        pre_d    = tick128 ? 10'd0 : (xtal_edge ? 10'(pre_q + 10'd1) : pre_q);
        frac_d   = tick128 ? rtc_wrap_inc(frac_q, RTC_FRAC_TOP) : frac_q;
        sec_d    = sec_tick ? rtc_wrap_inc(sec_q, RTC_MIN_SEC_TOP) : sec_q;
        min_d    = min_tick ? rtc_wrap_inc(min_q, RTC_MIN_SEC_TOP) : min_q;
        hour_d   = hour_tick ? rtc_wrap_inc(hour_q, hour_top) : hour_q;
        if (wr_frac) frac_d = sfr_wdata;
        if (wr_sec)  sec_d  = sfr_wdata;
        if (wr_min)  min_d  = sfr_wdata;
        if (wr_hour) hour_d = sfr_wdata;
        pin_d    = wr_pin ? sfr_wdata : pin_q;
        key_d    = (sfr_wr && sfr_addr == RTC_ADDR_KEY) ? sfr_wdata : key_q;
        ivl_d    = (sfr_wr && sfr_addr == RTC_ADDR_IVAL) ? sfr_wdata : ivl_q;
        nom_d    = (sfr_wr && sfr_addr == RTC_ADDR_NOM_TRIM) ? sfr_wdata : nom_q;
        temp_d   = (sfr_wr && sfr_addr == RTC_ADDR_TEMP_TRIM) ? sfr_wdata : temp_q;
        cfg_d    = cfg_q;
        if (wr_cfg) begin
            // Software can only clear the flags; writing a one keeps them.
            cfg_d = sfr_wdata;
            cfg_d[RTC_CFG_MIDNIGHT] = cfg_q[RTC_CFG_MIDNIGHT] & sfr_wdata[RTC_CFG_MIDNIGHT];
            cfg_d[RTC_CFG_ALARM]    = cfg_q[RTC_CFG_ALARM] & sfr_wdata[RTC_CFG_ALARM];
        end
        // Interval timer: held at zero while disabled, stops after one interval if single.
        itcnt_d = itcnt_q;
        done_d  = done_q;
        if (!cfg_q[RTC_CFG_TMR_EN]) begin
            itcnt_d = 8'h00;
            done_d  = 1'b0;
        end else if (base_tick && !done_q) begin
            if (8'(itcnt_q + 8'h01) >= ivl_q) begin
                itcnt_d = 8'h00;
                done_d  = cfg_q[RTC_CFG_SINGLE];
                cfg_d[RTC_CFG_ALARM] = 1'b1;
            end else begin
                itcnt_d = 8'(itcnt_q + 8'h01);
            end
        end
        // Set wins over a software clear arriving in the same cycle; a soft reset in that cycle still clears it.
        if (midnight_evt) cfg_d[RTC_CFG_MIDNIGHT] = 1'b1;
        // Watchdog or pin reset: the day mode bit, time counters and trims are kept; the interval counter clears.
        if (!soft_rstn) begin
            cfg_d   = {RTC_CFG_RESET[7], cfg_q[RTC_CFG_DAY_MODE], RTC_CFG_RESET[5:0]};
            key_d   = 8'h00;
            itcnt_d = 8'h00;
            done_d  = 1'b0;
        end
        unique case (sfr_addr)
            RTC_ADDR_CONFIG:    rdata_d = cfg_q;
            RTC_ADDR_FRAC:      rdata_d = frac_q;
            RTC_ADDR_SEC:       rdata_d = sec_q;
            RTC_ADDR_MIN:       rdata_d = min_q;
            RTC_ADDR_HOUR:      rdata_d = hour_q;
            RTC_ADDR_IVAL:      rdata_d = ivl_q;
            RTC_ADDR_NOM_TRIM:  rdata_d = nom_q;
            RTC_ADDR_TEMP_TRIM: rdata_d = temp_q;
            RTC_ADDR_KEY:       rdata_d = key_q;
            RTC_ADDR_INT_PIN:   rdata_d = pin_q;
            default:            rdata_d = 8'h00;
        endcase
        if (!sfr_rd) rdata_d = sfr_rdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers. Only the power-on reset reaches the time counters.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 10'd0;
            frac_q <= 8'h00;
            sec_q <= 8'h00;
            min_q <= 8'h00;
            hour_q <= 8'h00;
            cfg_q <= RTC_CFG_RESET;
            key_q <= 8'h00;
            ivl_q <= 8'h00;
            nom_q <= 8'h00;
            temp_q <= 8'h00;
            pin_q <= 8'h00;
            itcnt_q <= 8'h00;
            done_q <= 1'b0;
            sfr_rdata <= 8'h00;
            int_pin_cfg <= 8'h00;
            alarm_flag <= 1'b0;
            midnight_flag <= 1'b0;
            sleep_block <= 1'b0;
        end else begin
            pre_q <= pre_d;
            frac_q <= frac_d;
            sec_q <= sec_d;
            min_q <= min_d;
            hour_q <= hour_d;
            cfg_q <= cfg_d;
            key_q <= key_d;
            ivl_q <= ivl_d;
            nom_q <= nom_d;
            temp_q <= temp_d;
            pin_q <= pin_d;
            itcnt_q <= itcnt_d;
            done_q <= done_d;
            sfr_rdata <= rdata_d;
            int_pin_cfg <= pin_d;
            alarm_flag <= cfg_d[RTC_CFG_ALARM];
            midnight_flag <= cfg_d[RTC_CFG_MIDNIGHT];
            sleep_block <= cfg_d[RTC_CFG_MIDNIGHT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the protection, counter chain and flags.
    a_locked_sec_write: assert property (@(posedge clk) disable iff (!rstn)
        (sfr_wr && sfr_addr == RTC_ADDR_SEC && !unlocked && !sec_tick) |=> (sec_q == $past(sec_q)))
        else $error("locked seconds write changed the counter");
    a_unlocked_hour_write: assert property (@(posedge clk) disable iff (!rstn)
        (sfr_wr && sfr_addr == RTC_ADDR_HOUR && unlocked) |=> (hour_q == $past(sfr_wdata)))
        else $error("unlocked hours write not taken");
    a_frac_wrap_carry: assert property (@(posedge clk) disable iff (!rstn)
        (sec_tick && !sfr_wr && sec_q != RTC_MIN_SEC_TOP) |=> (frac_q == 8'h00 && sec_q == $past(sec_q) + 8'h01))
        else $error("fraction wrap did not carry into seconds");
    a_sec_min_wrap: assert property (@(posedge clk) disable iff (!rstn)
        (min_tick && !sfr_wr) |=> (sec_q == 8'h00 && (min_q == $past(min_q) + 8'h01 || min_q == 8'h00)))
        else $error("seconds wrap did not carry into minutes");
    a_hour_day_wrap: assert property (@(posedge clk) disable iff (!rstn)
        (hour_tick && !sfr_wr && cfg_q[RTC_CFG_DAY_MODE] && hour_q == 8'h17) |=> (hour_q == 8'h00))
        else $error("24-hour mode did not wrap at 23");
    a_hour_long_wrap: assert property (@(posedge clk) disable iff (!rstn)
        (hour_tick && !sfr_wr && !cfg_q[RTC_CFG_DAY_MODE] && hour_q == 8'h17) |=> (hour_q == 8'h18))
        else $error("256-hour mode wrapped early");
    a_midnight_sleep: assert property (@(posedge clk) disable iff (!rstn || !soft_rstn)
        midnight_evt ##1 !wr_cfg |-> (midnight_flag && sleep_block) [*2])
        else $error("midnight did not set flag and block sleep");
    a_timer_held: assert property (@(posedge clk) disable iff (!rstn)
        !cfg_q[RTC_CFG_TMR_EN] |=> (itcnt_q == 8'h00 && !done_q))
        else $error("disabled interval timer not held");
    a_soft_keeps_time: assert property (@(posedge clk) disable iff (!rstn)
        (!soft_rstn && !tick128 && !sfr_wr) |=>
            (hour_q == $past(hour_q) && cfg_q[RTC_CFG_DAY_MODE] == $past(cfg_q[RTC_CFG_DAY_MODE])))
        else $error("soft reset disturbed retained state");
endmodule

// ===== bench/rtc_cpu_model.sv
`timescale 1ns/1ps
// Processor side of the register port: one whole byte per access, no bit addressing.
module rtc_cpu_model (
    input  wire logic [7:0] sfr_rdata, // Read data from the core.
    input  wire logic       clk,       // System clock.
    output logic      [7:0] sfr_addr,  // Register address.
    output logic      [7:0] sfr_wdata, // Write byte.
    output logic            sfr_wr,    // Write strobe.
    output logic            sfr_rd     // Read strobe.
);
    import rtc_pkg::*;
    // Idle bus at time zero.
    initial begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = 18'h0;
    end
    // Lines are inverted on release so the core cannot lean on stale values.
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 {sfr_addr, sfr_wdata, sfr_wr} = {~a, ~d, 1'b0};
    endtask
    // Data is valid in the cycle after the taking edge.
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 {sfr_addr, sfr_rd} = {a, 1'b1};
        @(posedge clk);
        #1 d = sfr_rdata;
        {sfr_addr, sfr_rd} = {~a, 1'b0};
    endtask
    // Unlock, write, then lock again straight away.
    task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
        wr_byte(RTC_ADDR_KEY, RTC_KEY_UNLOCK);
        wr_byte(a, d);
        wr_byte(RTC_ADDR_KEY, 8'h00);
    endtask
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import rtc_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, soft_rstn = 1'b1, xtal_clk = 1'b0;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, int_pin_cfg, v;
    logic       sfr_wr, sfr_rd, alarm_flag, midnight_flag, sleep_block, got;
    int         num_errors = 0, check_count = 0, n;
    logic [7:0] cfg_t[3] = '{8'h41, 8'h01, 8'h01};
    logic [7:0] hr_t[3]  = '{8'h17, 8'h17, 8'hff};
    logic [7:0] eh_t[3]  = '{8'h00, 8'h18, 8'h00};
    // Crystal runs at 8 clk per period so ticks fit the run; the core only counts its edges.
    always #10 clk = ~clk;
    always #80 xtal_clk = ~xtal_clk;
    rtc_core rtc_core_inst (.clk(clk), .rstn(rstn), .soft_rstn(soft_rstn), .xtal_clk(xtal_clk),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .int_pin_cfg(int_pin_cfg), .alarm_flag(alarm_flag),
        .midnight_flag(midnight_flag), .sleep_block(sleep_block));
    rtc_cpu_model rtc_cpu_model_inst (.sfr_rdata(sfr_rdata), .clk(clk), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and comparison helpers.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] r;
        rtc_cpu_model_inst.rd_byte(a, r);
        chk(what, e, r);
    endtask
    // Polls seconds until they wrap; the bound covers one full tick with margin.
    task automatic wait_carry();
        for (n = 0; n < 2000; n++) begin
            rtc_cpu_model_inst.rd_byte(RTC_ADDR_SEC, v);
            if (v === 8'h00) return;
        end
        chk("carry wait", 8'h00, v);
        end_sim();
    endtask
    // Waits up to lim cycles for the alarm; an alarm that must come and does not ends the run.
    task automatic wait_alarm(input int lim, input logic must);
        got = 1'b0;
        for (n = 0; n < lim && !got; n++) begin
            @(posedge clk);
            #1 got = (alarm_flag === 1'b1);
        end
        if (must && !got) begin
            chk("alarm wait", 8'h01, 8'h00);
            end_sim();
        end
    endtask
    // Loads 59:59 with the fraction at its top; fraction goes last so no early carry is lost.
    task automatic preset(input logic [7:0] hr);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_SEC, RTC_MIN_SEC_TOP);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_MIN, RTC_MIN_SEC_TOP);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_HOUR, hr);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_FRAC, RTC_FRAC_TOP);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        rd_chk("config reset", RTC_ADDR_CONFIG, RTC_CFG_RESET);
        rd_chk("hour reset", RTC_ADDR_HOUR, 8'h00);
        rd_chk("unmapped", 8'h10, 8'h00);
        chk("flags reset", 8'h00, {5'h0, alarm_flag, midnight_flag, sleep_block});
        $display("test reset done");
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_SEC, 8'h10);
        rd_chk("sec locked", RTC_ADDR_SEC, 8'h00);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_SEC, 8'h10);
        rd_chk("sec unlocked", RTC_ADDR_SEC, 8'h10);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_SEC, 8'h20);
        rd_chk("sec relocked", RTC_ADDR_SEC, 8'h10);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_INT_PIN, 8'h80);
        chk("pin locked", 8'h00, int_pin_cfg);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_INT_PIN, 8'h80);
        chk("pin unlocked", 8'h80, int_pin_cfg);
        $display("test key done");
        for (int i = 0; i < 3; i++) begin
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, cfg_t[i]);
            preset(hr_t[i]);
            wait_carry();
            rd_chk("hour wrap", RTC_ADDR_HOUR, eh_t[i]);
            rd_chk("min wrap", RTC_ADDR_MIN, 8'h00);
            chk("midnight", {7'h0, eh_t[i] == 8'h00}, {7'h0, midnight_flag});
            chk("sleep block", {7'h0, eh_t[i] == 8'h00}, {7'h0, sleep_block});
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, cfg_t[i]);
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, cfg_t[i] | 8'h84);
            repeat (2) @(posedge clk);
            chk("flags cleared", 8'h00, {5'h0, alarm_flag, midnight_flag, sleep_block});
        end
        $display("test rollover done");
        for (int b = 0; b < 4; b++) begin
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_IVAL, 8'h01);
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h0b | 8'(b << 4));
            preset(8'h00);
            wait_carry();
            chk("alarm base", 8'h01, {7'h0, alarm_flag});
            rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h01);
            chk("alarm off", 8'h00, {7'h0, alarm_flag});
        end
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_IVAL, 8'h02);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h03);
        wait_alarm(5000, 1'b1);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h03);
        wait_alarm(5000, 1'b1);
        chk("repeat period", 8'h01, {7'h0, got && n > 4000 && n < 4200});
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h0b);
        wait_alarm(5000, 1'b1);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h0b);
        wait_alarm(7000, 1'b0);
        chk("single stops", 8'h00, {7'h0, got});
        $display("test interval done");
        // Trims sum to 8, so the tick that starts each second is 248 crystal edges long.
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_NOM_TRIM, 8'h10);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_TEMP_TRIM, 8'hf8);
        rd_chk("nominal trim", RTC_ADDR_NOM_TRIM, 8'h10);
        rd_chk("temperature trim", RTC_ADDR_TEMP_TRIM, 8'hf8);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_IVAL, 8'h01);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h01);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h03);
        // The first alarm marks a tick, so the fraction preset lands far from the next one.
        wait_alarm(3000, 1'b1);
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_FRAC, RTC_FRAC_TOP);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h03);
        wait_alarm(3000, 1'b1);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h03);
        wait_alarm(3000, 1'b1);
        chk("trimmed tick", 8'h01, {7'h0, n > 1970 && n < 1995});
        $display("test trim done");
        rtc_cpu_model_inst.prot_wr(RTC_ADDR_SEC, 8'h25);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_CONFIG, 8'h41);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_KEY, RTC_KEY_UNLOCK);
        @(posedge clk);
        #1 soft_rstn = 1'b0;
        @(posedge clk);
        #1 soft_rstn = 1'b1;
        rd_chk("sec kept", RTC_ADDR_SEC, 8'h25);
        rtc_cpu_model_inst.rd_byte(RTC_ADDR_CONFIG, v);
        chk("day mode kept", 8'h40, v & 8'h40);
        rtc_cpu_model_inst.wr_byte(RTC_ADDR_SEC, 8'h30);
        rd_chk("key cleared", RTC_ADDR_SEC, 8'h25);
        @(posedge clk);
        #1 rstn = 1'b0;
        @(posedge clk);
        #1 rstn = 1'b1;
        rd_chk("sec por", RTC_ADDR_SEC, 8'h00);
        rd_chk("config por", RTC_ADDR_CONFIG, RTC_CFG_RESET);
        $display("test resets done");
        end_sim();
    end
endmodule
